// *** hdl/sse_pkg.sv ***
// constants, mode encoding and bus layout for the speed-expansion link
// assumes one 125 MHz byte clock shared by every block of the switch
//
// Summary of operation
// RULE1: internal and external expansion never both active
// RULE2: slave keeps queues and address manager idle; link still takes free addresses until the 16-entry fifo fills
// RULE3: inputs of both devices load addresses together
// RULE4: paired outputs start their packets together
// RULE5: master port pairs with same-numbered slave port
// RULE6: internal mode joins port i with i+8
// RULE7: senders deliver within one byte clock of master
// RULE8: master or standalone drives its own sync; a master with sync_from_pin_i set takes the pin instead
// RULE9: external sync reaches both devices synchronously
// RULE10: slave takes sync pin as input
// RULE11: slave sequencer locks to received sync pulse
// RULE12: two address buses, input and output section
// RULE13: buses idle, driven by master, read by slave
// RULE14: input parity error drops address and packet
// RULE15: output parity error sends idle units instead
// RULE16: parity errors reported locally, never to master
// RULE17: at most one master with one slave
// RULE18: all controller addresses sent in 16 cycles
// RULE19: all bus parity errors merged into one event
// RULE20: sync restarts phase zero, fixed phase order
package sse_pkg;

   // ==========================================================
   // widths and depths
   localparam int ADDR_W     = 9;           // packet memory address
   localparam int BUS_W      = ADDR_W + 1;  // address plus valid flag
   localparam int PORT_N     = 16;
   localparam int PHASE_W    = 4;
   localparam int FIFO_DEPTH = 16;

   // ==========================================================
   // sequencer phases
   localparam logic [PHASE_W-1:0] PHASE_ZERO  = 4'h0;
   localparam logic [PHASE_W-1:0] PHASE_AFTER = 4'h1;  // phase following a sync cycle
   localparam logic [PHASE_W-1:0] PHASE_STEP  = 4'h1;
   localparam logic [PHASE_W-1:0] PAIR_OFFSET = 4'h8;  // port i joins port i+8

   // ==========================================================
   // bus word layout and parity
   localparam int   BUS_VALID_BIT = ADDR_W;     // msb flags a real address
   localparam logic PARITY_ODD    = 1'b1;       // ones in word plus parity is odd

   // ==========================================================
   // operating modes
   typedef enum logic [1:0] {
      SSE_MODE_SINGLE   = 2'b00,
      SSE_MODE_INTERNAL = 2'b01,
      SSE_MODE_MASTER   = 2'b10,
      SSE_MODE_SLAVE    = 2'b11
   } sse_mode_t;

endpackage : sse_pkg

// *** hdl/sse_strm_if.sv ***
// valid/ready stream carrying one word between link modules
// assumes both ends share the byte clock
interface sse_strm_if #(
   parameter int W = 9
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   // producer drives word and valid
   modport src (output valid, output data, input ready);
   // consumer drives ready
   modport snk (input valid, input data, output ready);
endinterface : sse_strm_if

// *** hdl/sse_fifo.sv ***
// synchronous fifo buffering free packet addresses
// assumes single clock; ready on write side is honest back-pressure
module sse_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 16
) (
   input  wire logic clock_i,
   input  wire logic rstn_i,
   sse_strm_if.snk   wr,
   sse_strm_if.src   rd
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [PW:0]  wptr_reg;
   logic [PW:0]  rptr_reg;
   logic         full;
   logic         empty;
   logic         push;
   logic         pop;

   // ==========================================================
   // flags from pointer compare
   assign empty    = (wptr_reg == rptr_reg);
   assign full     = (wptr_reg[PW] != rptr_reg[PW]) &&
                     (wptr_reg[PW-1:0] == rptr_reg[PW-1:0]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = mem[rptr_reg[PW-1:0]];
   assign push     = wr.valid && !full;
   assign pop      = rd.ready && !empty;

   // storage write
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wptr_reg[PW-1:0]] <= wr.data;
      end
   end

   // write pointer
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wptr_reg <= '0;
      end else if (push) begin
         wptr_reg <= wptr_reg + 1'b1;
      end
   end

   // read pointer
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rptr_reg <= '0;
      end else if (pop) begin
         rptr_reg <= rptr_reg + 1'b1;
      end
   end
endmodule : sse_fifo

// *** hdl/sse_link.sv ***
// speed-expansion link: sequencer, sync pin and master/slave address buses
// assumes config inputs are static while traffic flows and all pins are
// synchronous to the byte clock
module sse_link (
   input  wire logic                       clock_i,
   input  wire logic                       rstn_i,
   // configuration
   input  wire logic                       ext_en_i,
   input  wire logic                       ext_master_i,
   input  wire logic                       int_en_i,
   input  wire logic                       sync_from_pin_i,
   output logic                            cfg_conflict_o,
   output logic [1:0]                      mode_o,
   output logic                            queues_active_o,
   // sequencer sync pin, three signals
   input  wire logic                       sequencer_sync_pin_i,
   output logic                            sequencer_sync_pin_o,
   output logic                            sequencer_sync_pin_oe_n_o,
   output logic [sse_pkg::PHASE_W-1:0]     phase_o,
   // free addresses from the address manager
   input  wire logic                       free_addr_valid_i,
   input  wire logic [sse_pkg::ADDR_W-1:0] free_addr_i,
   output logic                            free_addr_ready_o,
   // retrieve address of the output queue of the current phase's port
   input  wire logic                       out_req_valid_i,
   input  wire logic [sse_pkg::ADDR_W-1:0] out_req_addr_i,
   // input-section address bus
   input  wire logic [sse_pkg::BUS_W-1:0]  ibus_data_i,
   input  wire logic                       ibus_par_i,
   output logic [sse_pkg::BUS_W-1:0]       ibus_data_o,
   output logic                            ibus_par_o,
   output logic                            ibus_oe_n_o,
   // output-section address bus
   input  wire logic [sse_pkg::BUS_W-1:0]  obus_data_i,
   input  wire logic                       obus_par_i,
   output logic [sse_pkg::BUS_W-1:0]       obus_data_o,
   output logic                            obus_par_o,
   output logic                            obus_oe_n_o,
   // new addresses to the input controllers
   output logic                            in_load_o,
   output logic [sse_pkg::PHASE_W-1:0]     in_port_o,
   output logic                            in_addr_valid_o,
   output logic [sse_pkg::ADDR_W-1:0]      in_addr_o,
   output logic                            in_pair_o,
   output logic                            in_drop_o,
   // retrieve addresses to the output controllers
   output logic                            out_start_o,
   output logic [sse_pkg::PHASE_W-1:0]     out_port_o,
   output logic [sse_pkg::ADDR_W-1:0]      out_addr_o,
   output logic                            out_idle_o,
   output logic                            out_pair_o,
   // parity error events
   output logic                            in_err_o,
   output logic                            out_err_o,
   output logic                            spx_err_o
);

   // ==========================================================
   // declarations
   sse_pkg::sse_mode_t          mode;
   logic                        conflict;
   logic                        is_slave;
   logic                        is_master;
   logic                        is_internal;
   logic                        sync_drive;
   logic                        sync_pulse;
   logic                        slot_tx;
   logic [sse_pkg::PHASE_W-1:0] phase_reg;
   logic [sse_pkg::PHASE_W-1:0] phase_next;
   logic                        sync_out_reg;
   logic [sse_pkg::BUS_W-1:0]   itx_reg;
   logic                        itx_par_reg;
   logic                        itx_slot_reg;
   logic [sse_pkg::PHASE_W-1:0] itx_port_reg;
   logic [sse_pkg::BUS_W-1:0]   otx_reg;
   logic                        otx_par_reg;
   logic [sse_pkg::BUS_W-1:0]   itx_next;
   logic [sse_pkg::BUS_W-1:0]   otx_next;
   logic [sse_pkg::BUS_W-1:0]   irx_word;
   logic [sse_pkg::BUS_W-1:0]   orx_word;
   logic                        rx_slot;
   logic [sse_pkg::PHASE_W-1:0] rx_port;
   logic                        in_perr;
   logic                        out_perr;
   logic                        cfg_conflict_reg;
   logic [1:0]                  mode_reg;
   logic                        queues_active_reg;
   logic                        in_load_reg;
   logic [sse_pkg::PHASE_W-1:0] in_port_reg;
   logic                        in_addr_valid_reg;
   logic [sse_pkg::ADDR_W-1:0]  in_addr_reg;
   logic                        in_pair_reg;
   logic                        in_drop_reg;
   logic                        out_start_reg;
   logic [sse_pkg::PHASE_W-1:0] out_port_reg;
   logic [sse_pkg::ADDR_W-1:0]  out_addr_reg;
   logic                        out_idle_reg;
   logic                        out_pair_reg;
   logic                        in_err_reg;
   logic                        out_err_reg;
   logic                        spx_err_reg;

   sse_strm_if #(.W(sse_pkg::ADDR_W)) free_wr ();
   sse_strm_if #(.W(sse_pkg::ADDR_W)) free_rd ();

   // ==========================================================
   // odd parity over one bus word
   function automatic logic bus_parity(input logic [sse_pkg::BUS_W-1:0] word);
      bus_parity = (^word) ^ sse_pkg::PARITY_ODD;
   endfunction : bus_parity

   // ==========================================================
   // mode decode
   // a conflicting setup falls back to plain sixteen-port operation
   always_comb begin
      conflict = ext_en_i && int_en_i;  // see RULE1
      if (conflict) begin
         mode = sse_pkg::SSE_MODE_SINGLE;  // see RULE1
      end else if (ext_en_i && ext_master_i) begin
         mode = sse_pkg::SSE_MODE_MASTER;
      end else if (ext_en_i) begin
         mode = sse_pkg::SSE_MODE_SLAVE;  // see RULE17
      end else if (int_en_i) begin
         mode = sse_pkg::SSE_MODE_INTERNAL;
      end else begin
         mode = sse_pkg::SSE_MODE_SINGLE;
      end
   end

   // per-mode role flags
   always_comb begin
      is_slave    = 1'b0;
      is_master   = 1'b0;
      is_internal = 1'b0;
      case (mode)
         sse_pkg::SSE_MODE_MASTER: begin
            is_master = 1'b1;
         end
         sse_pkg::SSE_MODE_SLAVE: begin
            is_slave = 1'b1;
         end
         sse_pkg::SSE_MODE_INTERNAL: begin
            is_internal = 1'b1;
         end
         default: begin
            is_master = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // sync pin and sequencer
   // slave always listens; master may opt to take an external sync
   assign sync_drive = !is_slave && !(is_master && sync_from_pin_i); // see RULE8 RULE10

   // sync source: own phase zero, or the pin when listening
   assign sync_pulse = sync_drive ? (phase_reg == sse_pkg::PHASE_ZERO)
                                  : sequencer_sync_pin_i;   // see RULE9 RULE11

   // a sync cycle is phase zero, so the next cycle is phase one
   assign phase_next = sync_pulse ? sse_pkg::PHASE_AFTER
                                  : phase_reg + sse_pkg::PHASE_STEP; // see RULE20 RULE18

   // phase counter, 16-cycle rotation
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_reg <= sse_pkg::PHASE_ZERO;
      end else begin
         phase_reg <= phase_next;  // see RULE11
      end
   end

   // outgoing sync is high for the whole phase-zero cycle
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_out_reg <= 1'b0;
      end else begin
         sync_out_reg <= (phase_next == sse_pkg::PHASE_ZERO); // see RULE8
      end
   end

   assign sequencer_sync_pin_o      = sync_out_reg;
   assign sequencer_sync_pin_oe_n_o = !sync_drive;          // see RULE8 RULE10
   assign phase_o                   = phase_reg;

   // ==========================================================
   // free address buffer
   // slave never pulls, so its address manager sees ready only until the 16-entry fifo fills
   assign slot_tx = !is_slave &&
                    (!is_internal || (phase_reg < sse_pkg::PAIR_OFFSET)); // see RULE2 RULE6

   assign free_wr.valid     = free_addr_valid_i;
   assign free_wr.data      = free_addr_i;
   assign free_addr_ready_o = free_wr.ready;                // see RULE2
   assign free_rd.ready     = slot_tx;

   sse_fifo #(
      .W     (sse_pkg::ADDR_W),
      .DEPTH (sse_pkg::FIFO_DEPTH)
   ) u_free_fifo (
      .clock_i (clock_i),
      .rstn_i  (rstn_i),
      .wr      (free_wr.snk),
      .rd      (free_rd.src)
   );

   // ==========================================================
   // transmit words for the current phase's port
   // phase p carries input and output controller p on both buses
   always_comb begin
      itx_next = '0;
      otx_next = '0;
      if (slot_tx) begin
         itx_next = {free_rd.valid, free_rd.data};          // see RULE3 RULE18
      end
      if (!is_slave) begin
         otx_next = {out_req_valid_i, out_req_addr_i};      // see RULE4 RULE18
      end
   end

   // input-section transmit register
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         itx_reg      <= '0;
         itx_par_reg  <= sse_pkg::PARITY_ODD;
         itx_slot_reg <= 1'b0;
         itx_port_reg <= sse_pkg::PHASE_ZERO;
      end else begin
         itx_reg      <= itx_next;
         itx_par_reg  <= bus_parity(itx_next);
         itx_slot_reg <= slot_tx;
         itx_port_reg <= phase_reg;
      end
   end

   // output-section transmit register
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         otx_reg     <= '0;
         otx_par_reg <= sse_pkg::PARITY_ODD;
      end else begin
         otx_reg     <= otx_next;
         otx_par_reg <= bus_parity(otx_next);
      end
   end

   // bus pins, released unless master of an external pair
   assign ibus_data_o = itx_reg;
   assign ibus_par_o  = itx_par_reg;
   assign ibus_oe_n_o = !is_master;  // see RULE12 RULE13
   assign obus_data_o = otx_reg;
   assign obus_par_o  = otx_par_reg;
   assign obus_oe_n_o = !is_master;  // see RULE12 RULE13

   // ==========================================================
   // receive side
   // master loops back its own bus word; slave reads the pins in the
   // same cycle, so both load on one edge
   always_comb begin
      if (is_slave) begin
         irx_word = ibus_data_i;
         orx_word = obus_data_i;
         rx_slot  = 1'b1;
         rx_port  = phase_reg - sse_pkg::PHASE_STEP;        // see RULE5
         in_perr  = (bus_parity(ibus_data_i) != ibus_par_i); // see RULE14
         out_perr = (bus_parity(obus_data_i) != obus_par_i); // see RULE15
      end else begin
         irx_word = itx_reg;
         orx_word = otx_reg;
         rx_slot  = itx_slot_reg;
         rx_port  = itx_port_reg;  // see RULE3 RULE4
         in_perr  = 1'b0;
         out_perr = 1'b0;
      end
   end

   // ==========================================================
   // input controller delivery
   // bad parity drops the address and tells the port not to store
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_load_reg       <= 1'b0;
         in_port_reg       <= sse_pkg::PHASE_ZERO;
         in_addr_valid_reg <= 1'b0;
         in_addr_reg       <= '0;
         in_pair_reg       <= 1'b0;
         in_drop_reg       <= 1'b0;
      end else begin
         in_load_reg       <= rx_slot && !in_perr;          // see RULE3 RULE14
         in_port_reg       <= rx_port;  // see RULE5
         in_addr_valid_reg <= irx_word[sse_pkg::BUS_VALID_BIT] && !in_perr;
         in_addr_reg       <= in_perr ? '0 : irx_word[sse_pkg::ADDR_W-1:0];
         in_pair_reg       <= rx_slot && is_internal;       // see RULE6
         in_drop_reg       <= rx_slot && in_perr;           // see RULE14
      end
   end

   // ==========================================================
   // output controller delivery
   // bad parity or no queued packet means idle units this slot
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_start_reg <= 1'b0;
         out_port_reg  <= sse_pkg::PHASE_ZERO;
         out_addr_reg  <= '0;
         out_idle_reg  <= 1'b1;
         out_pair_reg  <= 1'b0;
      end else begin
         out_start_reg <= rx_slot;  // see RULE4
         out_port_reg  <= rx_port;  // see RULE5
         out_addr_reg  <= out_perr ? '0 : orx_word[sse_pkg::ADDR_W-1:0];
         out_idle_reg  <= out_perr ||
                          !orx_word[sse_pkg::BUS_VALID_BIT]; // see RULE15
         out_pair_reg  <= rx_slot && is_internal;           // see RULE6
      end
   end

   // ==========================================================
   // error events, local only; nothing goes back over the buses
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         in_err_reg  <= 1'b0;
         out_err_reg <= 1'b0;
         spx_err_reg <= 1'b0;
      end else begin
         in_err_reg  <= in_perr;  // see RULE14 RULE16
         out_err_reg <= out_perr;  // see RULE15 RULE16
         spx_err_reg <= in_perr || out_perr;                // see RULE19
      end
   end

   // ==========================================================
   // configuration status
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_conflict_reg  <= 1'b0;
         mode_reg          <= sse_pkg::SSE_MODE_SINGLE;
         queues_active_reg <= 1'b1;
      end else begin
         cfg_conflict_reg  <= conflict;  // see RULE1
         mode_reg          <= mode;
         queues_active_reg <= !is_slave;  // see RULE2
      end
   end

   // ==========================================================
   // output assignments
   assign cfg_conflict_o  = cfg_conflict_reg;
   assign mode_o          = mode_reg;
   assign queues_active_o = queues_active_reg;
   assign in_load_o       = in_load_reg;
   assign in_port_o       = in_port_reg;
   assign in_addr_valid_o = in_addr_valid_reg;
   assign in_addr_o       = in_addr_reg;
   assign in_pair_o       = in_pair_reg;
   assign in_drop_o       = in_drop_reg;
   assign out_start_o     = out_start_reg;
   assign out_port_o      = out_port_reg;
   assign out_addr_o      = out_addr_reg;
   assign out_idle_o      = out_idle_reg;
   assign out_pair_o      = out_pair_reg;
   assign in_err_o        = in_err_reg;
   assign out_err_o       = out_err_reg;
   assign spx_err_o       = spx_err_reg;

endmodule : sse_link

// *** test/sse_link_checker.sv ***
// concurrent checks on the ports of the speed-expansion link
// assumes config inputs only change while reset is held
module sse_link_checker (
   input wire logic                      clock_i, rstn_i, ext_en_i, ext_master_i, int_en_i,
   input wire logic                      cfg_conflict_o, queues_active_o, sequencer_sync_pin_i,
   input wire logic                      sequencer_sync_pin_o, sequencer_sync_pin_oe_n_o,
   input wire logic [1:0]                mode_o,
   input wire logic [sse_pkg::PHASE_W-1:0] phase_o,
   input wire logic [sse_pkg::BUS_W-1:0] ibus_data_o,
   input wire logic                      ibus_par_o, ibus_oe_n_o, in_load_o, in_pair_o, in_drop_o,
   input wire logic [sse_pkg::ADDR_W-1:0] in_addr_o,
   input wire logic                      in_err_o, out_err_o, out_idle_o, spx_err_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // ========
   // sync pulse steps
   sequence sync_out;
      sequencer_sync_pin_o && !sequencer_sync_pin_oe_n_o;
   endsequence
   sequence quiet_then_sync;
      !sequencer_sync_pin_o [*8] ##8 sequencer_sync_pin_o;
   endsequence
   // ========
   // assertions
   chk_conflict_flag: assert property (
      ext_en_i && int_en_i |=> cfg_conflict_o && mode_o == 2'h0) else $error("conflict");
   chk_sync_period: assert property (
      sync_out |=> quiet_then_sync) else $error("sync period");
   chk_sync_phase: assert property (
      sequencer_sync_pin_o |-> phase_o == 4'h0) else $error("sync phase");
   chk_slave_lock: assert property (
      mode_o == sse_pkg::SSE_MODE_SLAVE && sequencer_sync_pin_i |=> phase_o == 4'h1)
      else $error("slave lock");
   chk_slave_idle: assert property (
      mode_o == sse_pkg::SSE_MODE_SLAVE |-> !queues_active_o && sequencer_sync_pin_oe_n_o)
      else $error("slave idle");
   chk_bus_drive: assert property (
      ibus_oe_n_o == !(ext_en_i && ext_master_i && !int_en_i)) else $error("bus drive");
   chk_bus_parity: assert property (
      !ibus_oe_n_o |-> ^{ibus_data_o, ibus_par_o}) else $error("bus parity");
   chk_load_timing: assert property (
      mode_o == sse_pkg::SSE_MODE_MASTER && ibus_data_o[9] |=> in_load_o
      && in_addr_o == $past(ibus_data_o[8:0])) else $error("load timing");
   chk_in_drop: assert property (
      in_err_o |-> in_drop_o && !in_load_o) else $error("input drop");
   chk_out_idle: assert property (
      out_err_o |-> out_idle_o) else $error("output idle");
   chk_err_merge: assert property (
      spx_err_o == (in_err_o || out_err_o)) else $error("error merge");
   chk_int_pair: assert property (
      mode_o == sse_pkg::SSE_MODE_INTERNAL && in_load_o |-> in_pair_o) else $error("pair");
endmodule : sse_link_checker

bind sse_link sse_link_checker u_chk (.clock_i, .rstn_i, .ext_en_i, .ext_master_i, .int_en_i,
   .cfg_conflict_o, .queues_active_o, .sequencer_sync_pin_i, .sequencer_sync_pin_o,
   .sequencer_sync_pin_oe_n_o, .mode_o, .phase_o, .ibus_data_o, .ibus_par_o, .ibus_oe_n_o,
   .in_load_o, .in_pair_o, .in_drop_o, .in_addr_o, .in_err_o, .out_err_o, .out_idle_o,
   .spx_err_o);

// *** test/sse_peer.sv ***
// master-side model feeding a slave link: sync pulse and both address buses
// assumes the shared byte clock; parity is corrupted only when told
module sse_peer (
   input  wire logic       clock_i,
   input  wire logic       rstn_i,
   input  wire logic       bad_par_i,
   output logic            sync_o,
   output logic [9:0]      ibus_o,
   output logic [9:0]      obus_o,
   output logic            ipar_o,
   output logic            opar_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] phase_reg;
   // free-running sequencer of the only master
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_reg <= 4'h0;
      end else begin
         phase_reg <= phase_reg + 4'h1;
      end
   end
   // words change every cycle, no skew against the sync
   always_comb begin
      sync_o = (phase_reg == 4'h0);
      ibus_o = {1'b1, 5'h15, phase_reg};
      obus_o = {1'b1, 5'h0A, ~phase_reg};
      ipar_o = ~^ibus_o ^ bad_par_i;
      opar_o = ~^obus_o ^ bad_par_i;
   end
endmodule : sse_peer

// *** test/sse_link_test.sv ***
// self-checking bench for the speed-expansion link in every mode
// assumes the peer model stands in for the master while the link is slave
module sse_link_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ========
   // signals
   logic clock_i = 1'b0, rstn_i = 1'b0, ext_en_i = 1'b0, ext_master_i = 1'b0, int_en_i = 1'b0;
   logic free_addr_valid_i = 1'b0, out_req_valid_i = 1'b0, bad = 1'b0, psync, pipar, popar;
   logic [8:0]  free_addr_i = 9'h000, out_req_addr_i = 9'h000, in_addr_o, expq[$];
   logic [15:0] lfsr = 16'h0003;
   logic [9:0]  pib, pob, ibus_data_o, obus_data_o, last_ib = 10'h000;
   logic [1:0]  rvh = 2'h0, mode_o;
   logic cfg_conflict_o, queues_active_o, free_addr_ready_o, sequencer_sync_pin_o;
   logic sequencer_sync_pin_oe_n_o, ibus_par_o, ibus_oe_n_o, obus_par_o, obus_oe_n_o;
   logic in_load_o, in_addr_valid_o, in_drop_o, out_start_o, out_idle_o, in_err_o;
   logic out_err_o, spx_err_o;
   int   errors = 0, checks_done = 0, cnt, scnt;
   wire logic sequencer_sync_pin_i = sequencer_sync_pin_oe_n_o ? psync : sequencer_sync_pin_o;
   wire logic [9:0] ibus_data_i = ibus_oe_n_o ? pib : ibus_data_o;
   wire logic [9:0] obus_data_i = obus_oe_n_o ? pob : obus_data_o;
   wire logic ibus_par_i = ibus_oe_n_o ? pipar : ibus_par_o;
   wire logic obus_par_i = obus_oe_n_o ? popar : obus_par_o;
   sse_link dut (.clock_i, .rstn_i, .ext_en_i, .ext_master_i, .int_en_i,
      .sync_from_pin_i(1'b0), .cfg_conflict_o, .mode_o, .queues_active_o,
      .sequencer_sync_pin_i, .sequencer_sync_pin_o, .sequencer_sync_pin_oe_n_o,
      .phase_o(), .free_addr_valid_i, .free_addr_i, .free_addr_ready_o,
      .out_req_valid_i, .out_req_addr_i, .ibus_data_i, .ibus_par_i, .ibus_data_o,
      .ibus_par_o, .ibus_oe_n_o, .obus_data_i, .obus_par_i, .obus_data_o, .obus_par_o,
      .obus_oe_n_o, .in_load_o, .in_port_o(), .in_addr_valid_o, .in_addr_o,
      .in_pair_o(), .in_drop_o, .out_start_o, .out_port_o(), .out_addr_o(), .out_idle_o,
      .out_pair_o(), .in_err_o, .out_err_o, .spx_err_o);
   sse_peer peer (.clock_i, .rstn_i, .bad_par_i(bad), .sync_o(psync), .ibus_o(pib),
      .obus_o(pob), .ipar_o(pipar), .opar_o(popar));
   // byte clock, 8 ns
   always #4 clock_i = ~clock_i;
   // ========
   // helpers
   function automatic logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : next_rand
   function automatic logic [1:0] exp_mode(input logic e, input logic m, input logic i);
      return (e && i) ? 2'h0 : (e ? {1'b1, ~m} : {1'b0, i});
   endfunction : exp_mode
   task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // reset for 20 cycles into a new configuration
   task automatic setup(input logic e, input logic m, input logic i);
      @(negedge clock_i);
      rstn_i = 1'b0;
      {ext_en_i, ext_master_i, int_en_i} = {e, m, i};
      free_addr_valid_i = 1'b0;
      bad = 1'b0;
      expq.delete();
      repeat (20) @(negedge clock_i);
      rstn_i = 1'b1;
      @(negedge clock_i);
      check("mode", 10'(mode_o), 10'(exp_mode(e, m, i)));
      check("conflict", 10'(cfg_conflict_o), 10'(e && i));
      last_ib = pib;
   endtask : setup
   // one cycle: judge settled outputs, then drive random traffic
   task automatic step(input logic push);
      @(negedge clock_i);
      cnt += in_load_o;
      scnt += sequencer_sync_pin_o;
      if (in_load_o && in_addr_valid_o && mode_o == 2'h2)
         check("load addr", 10'(in_addr_o), 10'(expq.pop_front()));
      if (in_load_o && mode_o == 2'h3) check("slave addr", 10'(in_addr_o), 10'(last_ib[8:0]));
      if (out_start_o && mode_o == 2'h2) check("out idle", 10'(out_idle_o), 10'(!rvh[1]));
      if (bad) check("errors", {5'h00, in_err_o, in_drop_o, out_err_o, out_idle_o, spx_err_o}, 10'h01F);
      lfsr = next_rand(lfsr);
      free_addr_valid_i = push | lfsr[0];
      free_addr_i = lfsr[9:1];
      out_req_valid_i = lfsr[10];
      out_req_addr_i = lfsr[15:7];
      rvh = {rvh[0], lfsr[10]};
      bad = (mode_o == 2'h3) && (lfsr[15:12] == 4'h0);
      last_ib = pib;
      if (free_addr_valid_i && free_addr_ready_o) expq.push_back(free_addr_i);
   endtask : step
   // ========
   // main sequence: master, slave, internal, conflicting config
   initial begin
      setup(1'b1, 1'b1, 1'b0);
      cnt = 0;
      scnt = 0;
      repeat (64) step(1'b0);
      check("sync count", 10'(scnt), 10'h004);
      setup(1'b1, 1'b0, 1'b0);
      repeat (20) step(1'b1);
      check("fifo full", {free_addr_ready_o, 9'(expq.size())}, 10'h010);
      repeat (300) step(1'b0);
      setup(1'b0, 1'b0, 1'b1);
      cnt = 0;
      repeat (32) step(1'b0);
      check("pair loads", 10'(cnt), 10'h010);
      setup(1'b1, 1'b1, 1'b1);
      repeat (16) step(1'b0);
      give_verdict();
   end
   // watchdog well beyond the roughly 520 cycles needed
   initial begin
      #(8 * 2000);
      errors++;
      give_verdict();
   end
endmodule : sse_link_test
